// ==== diag_led_ctrl.sv ====
// diagnostic led controller: apb registers, status and identify led drive
//
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
// What this block does
// (RL1) each identify button press toggles the identify led solid on or off
// (RL2) a remote identify request makes the identify led blink
// (RL3) status led shows off, green, blinking green, blinking amber or amber
// (RL4) state survives host power down; only ac power reset clears it
// (RL5) at ac power on, solid amber then at once blinking green
// (RL6) controller boot done without errors moves the led to solid green
// (RL7) status led off in off, low power off, s5 and s4 states; the code still shows fatal, warning and boot activity there
// (RL8) solid green only in s0, healthy, ac present, controller booted
// (RL9) degraded redundancy, fan and non-critical sensor conditions blink green
// (RL10) predictive supply failure and battery failure blink green
// (RL11) memory degradation conditions blink green
// (RL12) boot loader phase: status blinks green, identify blinks at 3 hz
// (RL13) os loading phase: identify solid on, status blinks green
// (RL14) watchdog reset and power unit config error blink green
// (RL15) impending failure conditions blink amber
// (RL16) fatal halted conditions give solid amber
// (RL17) most severe active condition wins
// (RL18) blink comes from a clock divider with 50 percent duty
module diag_led_ctrl
  import diag_led_pkg::*;
#(
  parameter logic [CNT_W-1:0] SLOW_HALF_CYCLES = SLOW_HALF,
  parameter logic [CNT_W-1:0] FAST_HALF_CYCLES = FAST_HALF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic id_button,
  output logic id_led,
  output led_drive_type status_led,
  output logic irq
);

  host_type host_reg;
  boot_type boot_reg;
  degrade_type degrade_reg;
  warn_type warn_reg;
  fatal_type fatal_reg;
  logic ident_remote_reg;
  logic id_solid_reg;
  logic btn_prev_reg;
  logic ac_fresh_reg;
  logic err_reg;
  status_mode_type mode_reg;
  status_mode_type mode_next;
  id_mode_type id_mode_reg;
  id_mode_type id_mode_next;
  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_en_reg;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;
  logic slow_blink;
  logic fast_blink;
  logic wr_en;
  logic btn_rise;
  logic boot_busy;
  logic [31:0] rd_next;
  logic err_next;
  status_word_type stat_word;

  // led colour drive for a status mode at the current blink phase
  function automatic led_drive_type drive_of(input status_mode_type m, input logic b);
    led_drive_type d;
    d = '{green: 1'b0, amber: 1'b0};
    case (m)
      ST_GREEN: d.green = 1'b1;
      ST_GREEN_BLINK: d.green = b;
      ST_AMBER_BLINK: d.amber = b;
      ST_AMBER: d.amber = 1'b1;
      default: d = '{green: 1'b0, amber: 1'b0};
    endcase
    return d;
  endfunction

  // any host state other than s0 is a powered down state
  function automatic logic host_off(input logic [2:0] p);
    return p != PWR_S0;
  endfunction

  // blink sources
  blink_divider #(.HALF_CYCLES(SLOW_HALF_CYCLES)) u_slow (
    .pclk(pclk),
    .presetn(presetn),
    .blink(slow_blink)
  );

  blink_divider #(.HALF_CYCLES(FAST_HALF_CYCLES)) u_fast (
    .pclk(pclk),
    .presetn(presetn),
    .blink(fast_blink)
  );

  // apb handshake: zero wait states, errors only in the access phase
  assign pready = 1'b1;
  assign pslverr = psel & penable & err_reg;
  assign wr_en = psel & penable & pwrite;
  assign btn_rise = id_button & ~btn_prev_reg;
  assign boot_busy = boot_reg.phase != BOOT_DONE;

  // condition registers; reset only on ac power, so host power down keeps them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_reg <= HOST_RST;
      boot_reg <= BOOT_RST;
      degrade_reg <= '0;
      warn_reg <= '0;
      fatal_reg <= '0;
    end else if (wr_en) begin
      case (paddr)
        REG_HOST: host_reg <= host_type'(pwdata[$bits(host_type)-1:0]); // RL4
        REG_BOOT: boot_reg <= boot_type'(pwdata[$bits(boot_type)-1:0]);
        REG_DEGRADE: degrade_reg <= degrade_type'(pwdata[$bits(degrade_type)-1:0]);
        REG_WARN: warn_reg <= warn_type'(pwdata[$bits(warn_type)-1:0]);
        REG_FATAL: fatal_reg <= fatal_type'(pwdata[$bits(fatal_type)-1:0]);
        default: ;
      endcase
    end
  end

  // identify inputs: remote request bit and the button toggle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ident_remote_reg <= 1'b0;
      id_solid_reg <= 1'b0;
      btn_prev_reg <= 1'b0;
    end else begin
      btn_prev_reg <= id_button;
      if (wr_en && paddr == REG_IDENT) begin
        ident_remote_reg <= pwdata[0]; // RL2
      end
      if (btn_rise) begin
        id_solid_reg <= ~id_solid_reg; // RL1
      end
    end
  end

  // first cycle after ac power on shows amber before the boot indication
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ac_fresh_reg <= 1'b1;
    end else begin
      ac_fresh_reg <= 1'b0; // RL5
    end
  end

  // status mode by severity; boot activity is shown even with the host down
  always_comb begin
    if (ac_fresh_reg) begin
      mode_next = ST_AMBER; // RL5
    end else if (|fatal_reg) begin
      mode_next = ST_AMBER; // RL16 RL17
    end else if (|warn_reg) begin
      mode_next = ST_AMBER_BLINK; // RL15 RL17
    end else if (boot_busy) begin
      mode_next = ST_GREEN_BLINK; // RL5 RL12 RL13
    end else if (host_off(host_reg.pwr)) begin
      mode_next = ST_OFF; // RL7
    end else if (|degrade_reg || boot_reg.wdog) begin
      mode_next = ST_GREEN_BLINK; // RL9 RL10 RL11 RL14
    end else if (host_reg.ac_present) begin
      mode_next = ST_GREEN; // RL6 RL8
    end else begin
      mode_next = ST_OFF;
    end
  end

  // identify mode: boot phases override the remote request and the button
  always_comb begin
    if (boot_reg.phase == BOOT_LOADER) begin
      id_mode_next = ID_BLINK_FAST; // RL12
    end else if (boot_reg.phase == BOOT_OS) begin
      id_mode_next = ID_SOLID; // RL13
    end else if (fatal_reg.bad_ctrl_mem || fatal_reg.bad_images) begin
      id_mode_next = ID_SOLID;
    end else if (ident_remote_reg) begin
      id_mode_next = ID_BLINK_SLOW; // RL2
    end else if (id_solid_reg) begin
      id_mode_next = ID_SOLID; // RL1
    end else begin
      id_mode_next = ID_OFF;
    end
  end

  // mode state; reset shows amber as soon as standby power arrives
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= ST_AMBER;
      id_mode_reg <= ID_OFF;
    end else begin
      mode_reg <= mode_next;
      id_mode_reg <= id_mode_next;
    end
  end

  // led pins from flops; one drive feeds board and front panel copies
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_led <= '{green: 1'b0, amber: 1'b1};
      id_led <= 1'b0;
    end else begin
      status_led <= drive_of(mode_reg, slow_blink); // RL3 RL9 RL18
      id_led <= (id_mode_reg == ID_SOLID) ||
                (id_mode_reg == ID_BLINK_SLOW && slow_blink) ||
                (id_mode_reg == ID_BLINK_FAST && fast_blink); // RL12
    end
  end

  // interrupt events; a set in the clearing cycle wins
  assign irq_set[IRQ_BTN] = btn_rise;
  assign irq_set[IRQ_MODE] = mode_next != mode_reg;
  assign irq_clr = (wr_en && paddr == REG_IRQ_CLR) ? pwdata[IRQ_W-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_reg <= '0;
      irq_en_reg <= IRQ_EN_RST;
      irq <= 1'b0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
      if (wr_en && paddr == REG_IRQ_EN) begin
        irq_en_reg <= pwdata[IRQ_W-1:0];
      end
      irq <= |(irq_stat_reg & irq_en_reg);
    end
  end

  // read mux; write to a read-only or unmapped word is an error
  always_comb begin
    stat_word = '{led: status_led, id_led: id_led, id_solid: id_solid_reg,
                  id_mode: id_mode_reg, mode: mode_reg};
    rd_next = '0;
    err_next = 1'b0;
    case (paddr)
      REG_HOST: rd_next = 32'(host_reg);
      REG_BOOT: rd_next = 32'(boot_reg);
      REG_DEGRADE: rd_next = 32'(degrade_reg);
      REG_WARN: rd_next = 32'(warn_reg);
      REG_FATAL: rd_next = 32'(fatal_reg);
      REG_IDENT: rd_next = 32'(ident_remote_reg);
      REG_STATUS: begin
        rd_next = 32'(stat_word);
        err_next = pwrite;
      end
      REG_IRQ_STAT: begin
        rd_next = 32'(irq_stat_reg);
        err_next = pwrite;
      end
      REG_IRQ_CLR: rd_next = '0;
      REG_IRQ_EN: rd_next = 32'(irq_en_reg);
      default: err_next = 1'b1;
    endcase
  end

  // read data and error are captured in the setup cycle, so no wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      err_reg <= 1'b0;
    end else if (psel && !penable) begin
      prdata <= pwrite ? '0 : rd_next;
      err_reg <= err_next;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_btn_toggle; // RL1
    btn_rise |=> id_solid_reg != $past(id_solid_reg);
  endproperty
  a_btn_toggle: assert property (p_btn_toggle) else $error("button did not toggle");

  property p_remote_blink; // RL2
    ident_remote_reg && !boot_reg.phase[1] && !fatal_reg.bad_ctrl_mem &&
      !fatal_reg.bad_images |=> id_mode_reg == ID_BLINK_SLOW ##1 id_led == $past(slow_blink);
  endproperty
  a_remote_blink: assert property (p_remote_blink) else $error("remote identify not blinking");

  property p_amber_drive; // RL3
    mode_reg == ST_AMBER |=> status_led.amber && !status_led.green;
  endproperty
  a_amber_drive: assert property (p_amber_drive) else $error("amber drive wrong");

  sequence s_ac_boot;
    mode_reg == ST_AMBER ##1 mode_reg == ST_GREEN_BLINK;
  endsequence
  // anchored on the fall of the first-cycle flag, so the release edge itself is never judged
  property p_ac_boot; // RL5
    $fell(ac_fresh_reg) && !$past(wr_en) |-> s_ac_boot;
  endproperty
  a_ac_boot: assert property (p_ac_boot) else $error("power on sequence wrong");

  property p_healthy; // RL6 RL8
    !ac_fresh_reg && fatal_reg == '0 && warn_reg == '0 && degrade_reg == '0 &&
      boot_reg == '0 && host_reg.pwr == PWR_S0 && host_reg.ac_present |=> mode_reg == ST_GREEN;
  endproperty
  a_healthy: assert property (p_healthy) else $error("healthy system not solid green");

  property p_off; // RL7
    !ac_fresh_reg && fatal_reg == '0 && warn_reg == '0 && !boot_busy &&
      host_off(host_reg.pwr) |=> mode_reg == ST_OFF ##1 status_led == '0;
  endproperty
  a_off: assert property (p_off) else $error("status led not off when host down");

  property p_degraded; // RL9 RL10 RL11 RL14
    !ac_fresh_reg && fatal_reg == '0 && warn_reg == '0 && !boot_busy &&
      host_reg.pwr == PWR_S0 && (|degrade_reg || boot_reg.wdog) |=> mode_reg == ST_GREEN_BLINK;
  endproperty
  a_degraded: assert property (p_degraded) else $error("degraded not blinking green");

  property p_green_blink; // RL9 RL18
    mode_reg == ST_GREEN_BLINK |=> status_led.green == $past(slow_blink) && !status_led.amber;
  endproperty
  a_green_blink: assert property (p_green_blink) else $error("green blink drive wrong");

  property p_fatal; // RL16 RL17
    !ac_fresh_reg && |fatal_reg |=> mode_reg == ST_AMBER;
  endproperty
  a_fatal: assert property (p_fatal) else $error("fatal not solid amber");

  property p_warn; // RL15 RL17
    !ac_fresh_reg && fatal_reg == '0 && |warn_reg |=> mode_reg == ST_AMBER_BLINK;
  endproperty
  a_warn: assert property (p_warn) else $error("warning not blinking amber");

  property p_loader; // RL12
    boot_reg.phase == BOOT_LOADER |=> id_mode_reg == ID_BLINK_FAST ##1 id_led == $past(fast_blink);
  endproperty
  a_loader: assert property (p_loader) else $error("loader identify not fast blink");

  property p_os_load; // RL13
    boot_reg.phase == BOOT_OS |=> id_mode_reg == ID_SOLID ##1 id_led;
  endproperty
  a_os_load: assert property (p_os_load) else $error("os load identify not solid");

  property p_half_period; // RL18
    $changed(slow_blink) |=> $stable(slow_blink) [*8];
  endproperty
  a_half_period: assert property (p_half_period) else $error("blink half period too short");

  property p_set_wins;
    irq_set[IRQ_MODE] |=> irq_stat_reg[IRQ_MODE] ##1 (irq || !$past(irq_en_reg[IRQ_MODE]));
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("interrupt event lost");

  c_green: cover property (mode_reg == ST_GREEN_BLINK ##1 mode_reg == ST_GREEN);
  c_amber_blink: cover property (mode_reg == ST_AMBER_BLINK);
  c_fast_id: cover property (id_mode_reg == ID_BLINK_FAST ##1 id_led);
  c_irq: cover property ($rose(irq));

endmodule // diag_led_ctrl

// ==== diag_led_pkg.sv ====
// package: register map, field layouts, led modes and blink timing
package diag_led_pkg;

  // apb register byte offsets
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_HOST = 8'h00;
  localparam logic [ADDR_W-1:0] REG_BOOT = 8'h04;
  localparam logic [ADDR_W-1:0] REG_DEGRADE = 8'h08;
  localparam logic [ADDR_W-1:0] REG_WARN = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_FATAL = 8'h10;
  localparam logic [ADDR_W-1:0] REG_IDENT = 8'h14;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h18;
  localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 8'h1c;
  localparam logic [ADDR_W-1:0] REG_IRQ_CLR = 8'h20;
  localparam logic [ADDR_W-1:0] REG_IRQ_EN = 8'h24;

  // host power state codes; everything but s0 counts as powered down
  localparam logic [2:0] PWR_S0 = 3'h0;
  localparam logic [2:0] PWR_OFF = 3'h1;
  localparam logic [2:0] PWR_LOW_POWER_OFF = 3'h2;
  localparam logic [2:0] PWR_S5 = 3'h3;
  localparam logic [2:0] PWR_S4 = 3'h4;

  // management controller boot phases
  localparam logic [1:0] BOOT_DONE = 2'h0;
  localparam logic [1:0] BOOT_BUSY = 2'h1;
  localparam logic [1:0] BOOT_LOADER = 2'h2;
  localparam logic [1:0] BOOT_OS = 2'h3;

  // interrupt status bits
  localparam int IRQ_W = 2;
  localparam int IRQ_BTN = 0;
  localparam int IRQ_MODE = 1;
  localparam logic [IRQ_W-1:0] IRQ_EN_RST = 2'h0;

  // blink timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned CLK_HZ = 1000000000 / CLK_PERIOD_NS;
  localparam int unsigned SLOW_BLINK_HZ = 1;
  localparam int unsigned FAST_BLINK_HZ = 3;
  localparam int CNT_W = 26;
  localparam logic [CNT_W-1:0] SLOW_HALF = CNT_W'(CLK_HZ / (2 * SLOW_BLINK_HZ));
  localparam logic [CNT_W-1:0] FAST_HALF = CNT_W'(CLK_HZ / (2 * FAST_BLINK_HZ));

  typedef enum logic [4:0] {
    ST_OFF = 5'h01,
    ST_GREEN = 5'h02,
    ST_GREEN_BLINK = 5'h04,
    ST_AMBER_BLINK = 5'h08,
    ST_AMBER = 5'h10
  } status_mode_type;

  typedef enum logic [3:0] {
    ID_OFF = 4'h1,
    ID_SOLID = 4'h2,
    ID_BLINK_SLOW = 4'h4,
    ID_BLINK_FAST = 4'h8
  } id_mode_type;

  typedef struct packed {
    logic green;
    logic amber;
  } led_drive_type;

  typedef struct packed {
    logic ac_present;
    logic [2:0] pwr;
  } host_type;

  typedef struct packed {
    logic wdog;
    logic [1:0] phase;
  } boot_type;

  // degraded conditions, bit 0 is psu_redund
  typedef struct packed {
    logic pu_cfg_err;
    logic mirror_ce_limit;
    logic mirror_ue;
    logic spare_gone;
    logic mem_partial;
    logic battery;
    logic psu_predict;
    logic nc_thermctl;
    logic nc_power;
    logic nc_volt;
    logic nc_temp;
    logic fan_fault;
    logic fan_redund;
    logic psu_redund;
  } degrade_type;

  // impending failure conditions
  typedef struct packed {
    logic psu_short;
    logic drive_fault;
    logic few_fans;
    logic crit_thresh;
  } warn_type;

  // fatal conditions
  typedef struct packed {
    logic bad_images;
    logic bad_ctrl_mem;
    logic no_memory;
    logic power_fault;
    logic cpu_thermtrip;
    logic cpu_caterr;
  } fatal_type;

  typedef struct packed {
    led_drive_type led;
    logic id_led;
    logic id_solid;
    id_mode_type id_mode;
    status_mode_type mode;
  } status_word_type;

  localparam host_type HOST_RST = '{ac_present: 1'b1, pwr: PWR_OFF};
  localparam boot_type BOOT_RST = '{wdog: 1'b0, phase: BOOT_BUSY};

endpackage

// ==== blink_divider.sv ====
// blink divider: square wave with equal high and low halves
`timescale 1ns/1ps
module blink_divider
  import diag_led_pkg::*;
#(
  parameter logic [CNT_W-1:0] HALF_CYCLES = SLOW_HALF
) (
  input wire logic pclk,
  input wire logic presetn,
  output logic blink
);

  logic [CNT_W-1:0] cnt_reg;

  // count one half period, then flip the output for a 50 percent duty
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= '0;
      blink <= 1'b0;
    end else if (cnt_reg >= HALF_CYCLES - 1'b1) begin
      cnt_reg <= '0;
      blink <= ~blink; // RL18
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

endmodule // blink_divider

// ==== panel_model.sv ====
// partner model: front panel identify button and led observer
`timescale 1ns/1ps
module panel_model
  import diag_led_pkg::*;
(
  input wire logic pclk,
  input wire logic id_led,
  input wire led_drive_type status_led,
  output logic id_button
);
  int green_run = 0;
  int id_run = 0;
  int g_cnt = 0;
  int i_cnt = 0;

  initial id_button = 1'b0;

  // one press, held a few cycles as a finger would; release before the next press
  task automatic press();
    @(posedge pclk);
    id_button <= 1'b1;
    repeat (4) @(posedge pclk);
    id_button <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask

  // length of the last lit run of the green status led and the identify led, so blink halves can be judged
  always @(posedge pclk) begin
    g_cnt <= status_led.green ? g_cnt + 1 : 0;
    if (!status_led.green && g_cnt != 0) green_run <= g_cnt;
    i_cnt <= id_led ? i_cnt + 1 : 0;
    if (!id_led && i_cnt != 0) id_run <= i_cnt;
  end
endmodule // panel_model

// ==== testbench.sv ====
// testbench: apb stimulus, led state model and comparisons
`timescale 1ns/1ps
module testbench;
  import diag_led_pkg::*;
  localparam logic [CNT_W-1:0] SLOW_T = 26'h18;
  localparam logic [CNT_W-1:0] FAST_T = 26'h10;
  logic pclk, presetn, psel, penable, pwrite, pslverr, pready, id_button, id_led, irq;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd, r;
  logic er;
  led_drive_type status_led;
  int error_cnt = 0;
  int total_checks = 0;
  int h, b, dg, w, f, idn, tog, k;
  integer seed;

  diag_led_ctrl #(.SLOW_HALF_CYCLES(SLOW_T), .FAST_HALF_CYCLES(FAST_T)) dut (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .id_button(id_button), .id_led(id_led), .status_led(status_led), .irq(irq));
  panel_model u_panel (.pclk(pclk), .id_led(id_led), .status_led(status_led),
    .id_button(id_button));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // one apb transfer; holds the request until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 100) begin
        chk(0, 1, "pready timeout");
        final_report();
      end
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // reference: led mode by severity, identify mode by boot phase and requests
  function automatic logic [9:0] model();
    logic [4:0] m;
    logic [3:0] i;
    if (f != 0) m = 5'h10;
    else if (w != 0) m = 5'h08;
    else if ((b & 3) != 0) m = 5'h04;
    else if ((h & 7) != 0) m = 5'h01;
    else if (dg != 0 || (b & 4) != 0) m = 5'h04;
    else if ((h & 8) != 0) m = 5'h02;
    else m = 5'h01;
    if ((b & 3) == 2) i = 4'h8;
    else if ((b & 3) == 3) i = 4'h2;
    else if ((f & 6'h30) != 0) i = 4'h2;
    else if ((idn & 1) != 0) i = 4'h4;
    else if (tog != 0) i = 4'h2;
    else i = 4'h1;
    return {tog[0], i, m};
  endfunction

  // mode lands one edge after the write, so let a few edges pass before reading
  task automatic check_status(input string msg);
    repeat (3) @(posedge pclk);
    apb(1'b0, REG_STATUS, 32'h0);
    chk({22'h0, rd[9:0]}, {22'h0, model()}, msg);
  endtask

  task automatic set_all(input int nh, nb, ndg, nw, nf, nid);
    h = nh; b = nb; dg = ndg; w = nw; f = nf; idn = nid;
    apb(1'b1, REG_HOST, h);
    apb(1'b1, REG_BOOT, b);
    apb(1'b1, REG_DEGRADE, dg);
    apb(1'b1, REG_WARN, w);
    apb(1'b1, REG_FATAL, f);
    apb(1'b1, REG_IDENT, idn);
  endtask

  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = '0; pwdata = '0; seed = 32'h0c25d8d9; tog = 0;
    h = 9; b = 1; dg = 0; w = 0; f = 0; idn = 0;
    repeat (10) @(posedge pclk);
    chk({30'h0, status_led}, 32'h1, "amber at power on");
    presetn <= 1'b1;
    apb(1'b0, REG_HOST, 0); chk(rd, 32'h9, "host reset");
    apb(1'b0, REG_BOOT, 0); chk(rd, 32'h1, "boot reset");
    apb(1'b0, REG_IRQ_EN, 0); chk(rd, 32'h0, "irq enable reset");
    check_status("booting blinks green");
    set_all(9, 0, 0, 0, 0, 0);
    check_status("booted with host off is off");
    set_all(8, 1, 0, 0, 0, 0);
    check_status("booting in s0 blinks green");
    set_all(8, 0, 0, 0, 0, 0);
    check_status("boot done solid green");
    set_all(8, 0, 0, 0, 0, 0);
    check_status("healthy s0");
    set_all(8, 0, 5, 0, 0, 0);
    for (k = 1; k <= 4; k++) begin
      h = 8 | k;
      apb(1'b1, REG_HOST, h);
      check_status("host down is off");
    end
    apb(1'b0, REG_DEGRADE, 0); chk(rd, 32'h5, "state kept while down");
    for (k = 0; k < 14; k++) begin
      set_all(8, 0, 1 << k, 0, 0, 0);
      check_status("degraded blinks green");
    end
    set_all(8, 4, 0, 0, 0, 0);
    check_status("watchdog reset blinks green");
    for (k = 0; k < 4; k++) begin
      set_all(8, 0, 1, 1 << k, 0, 0);
      check_status("warning blinks amber");
    end
    for (k = 0; k < 6; k++) begin
      set_all(8, 0, 1, 1, 1 << k, 0);
      check_status("fatal solid amber");
    end
    for (k = 0; k < 16; k++) begin
      r = $random(seed);
      set_all((r[3] ? 8 : 0) + r[6:4] % 5, r[10:8], r[24:11], r[28:25] & {4{r[29]}},
        (r[30] & r[31]) ? r[13:8] : 0, r[2]);
      check_status("most severe wins");
    end
    set_all(8, 0, 1, 0, 0, 0);
    repeat (4 * SLOW_T) @(posedge pclk);
    chk(u_panel.green_run, SLOW_T, "slow blink half");
    set_all(8, 0, 0, 0, 0, 1);
    check_status("remote identify blinks");
    repeat (4 * SLOW_T) @(posedge pclk);
    chk(u_panel.id_run, SLOW_T, "identify blink half");
    set_all(8, 2, 0, 0, 0, 0);
    check_status("boot loader fast identify");
    repeat (4 * SLOW_T) @(posedge pclk);
    chk(u_panel.id_run, FAST_T, "fast blink half");
    set_all(8, 3, 0, 0, 0, 0);
    check_status("os loading identify solid");
    set_all(8, 0, 0, 0, 0, 0);
    apb(1'b1, REG_IRQ_CLR, 3);
    apb(1'b1, REG_IRQ_EN, 1);
    u_panel.press();
    tog = 1;
    check_status("press lights identify");
    chk(irq, 1, "press raises irq");
    apb(1'b0, REG_IRQ_STAT, 0); chk(rd & 1, 1, "press status bit");
    apb(1'b1, REG_IRQ_CLR, 3);
    repeat (3) @(posedge pclk);
    chk(irq, 0, "irq cleared");
    // mode-change interrupt: enable only that bit, then move the status mode
    apb(1'b1, REG_IRQ_EN, 2);
    dg = 1;
    apb(1'b1, REG_DEGRADE, dg);
    repeat (3) @(posedge pclk);
    chk(irq, 1, "mode change raises irq");
    dg = 0;
    apb(1'b1, REG_DEGRADE, dg);
    apb(1'b1, REG_IRQ_EN, 0);
    u_panel.press();
    tog = 0;
    check_status("second press turns off");
    chk(irq, 0, "masked irq stays low");
    apb(1'b0, 8'h28, 0); chk({31'h0, er}, 1, "unmapped read error");
    chk(rd, 0, "unmapped read data");
    apb(1'b1, REG_STATUS, 32'h1f); chk({31'h0, er}, 1, "read only write error");
    apb(1'b1, 8'h02, 32'h1); chk({31'h0, er}, 1, "unaligned error");
    check_status("refused writes change nothing");
    final_report();
  end
endmodule // testbench
